// ===== core/pmi_match.sv
// Port pattern-match interrupt unit with an APB register slave.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pmi_params.svh"

module pmi_match #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             pclk,
   input  wire logic             presetn,
   // APB slave.
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Port pins and system.
   input  wire logic [WIDTH-1:0] port_in,
   output logic                  pattern_match_interrupt,
   output logic                  wake_request
);

   // ---------------------------------------------------------------
   // Registers and bus decode
   // ---------------------------------------------------------------
   logic [WIDTH-1:0]   pin_select_mask;
   logic [WIDTH-1:0]   match_pattern_value;
   pmi_pkg::pmi_ctl_s  match_control_reg;
   logic               irq_status;
   logic               irq_mask;
   logic [2:0]         hold_count;
   pmi_pkg::pmi_state_e state;
   logic               cond;
   logic               set_event;
   logic               acc;
   logic               wr;
   logic               mapped;
   logic [31:0]        next_rdata;

   assign acc = psel & penable & pready;
   assign wr  = acc & pwrite;

   // Address decode picks the read value and flags unmapped offsets.
   always_comb begin
      mapped     = 1'b1;
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         `PMI_OFF_MASK: begin
            next_rdata[WIDTH-1:0] = pin_select_mask;
         end
         `PMI_OFF_PATTERN: begin
            next_rdata[WIDTH-1:0] = match_pattern_value;
         end
         `PMI_OFF_CONTROL: begin
            next_rdata[2:0] = match_control_reg;
         end
         `PMI_OFF_IRQ_STAT: begin
            next_rdata[0] = irq_status;
         end
         `PMI_OFF_IRQ_MASK: begin
            next_rdata[0] = irq_mask;
         end
         `PMI_OFF_PORT: begin
            next_rdata[WIDTH-1:0] = port_in;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Ready is given in the access phase's second clock cycle: one wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ?
                    next_rdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // Mask and pattern registers, cleared to inactive on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_select_mask     <= `PMI_RST_MASK;
         match_pattern_value <= `PMI_RST_PATTERN;
         irq_mask            <= 1'b0;
      end else if (wr) begin
         if (paddr == `PMI_OFF_MASK)
            pin_select_mask <= pwdata[WIDTH-1:0];
         if (paddr == `PMI_OFF_PATTERN)
            match_pattern_value <= pwdata[WIDTH-1:0];
         if (paddr == `PMI_OFF_IRQ_MASK)
            irq_mask <= pwdata[0];
      end
   end

   // ---------------------------------------------------------------
   // Match condition and persistence filter
   // ---------------------------------------------------------------

   // Masked compare; polarity picks equal or not-equal.
   always_comb begin
      logic eq;
      eq   = ((port_in ^ match_pattern_value) & pin_select_mask) == '0;
      cond = match_control_reg.enable &
             (match_control_reg.polarity ? ~eq : eq);
   end

   // Condition must stay true longer than the hold count to qualify.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= pmi_pkg::PMI_IDLE;
         hold_count <= 3'h0;
      end else if (!cond) begin
         state      <= pmi_pkg::PMI_IDLE;
         hold_count <= 3'h0;
      end else begin
         unique case (state)
            pmi_pkg::PMI_IDLE: begin
               state      <= pmi_pkg::PMI_COUNT;
               hold_count <= 3'h1;
            end
            pmi_pkg::PMI_COUNT: begin
               if (hold_count == 3'(`PMI_HOLD_CLOCKS)) begin
                  state <= pmi_pkg::PMI_HELD;
               end else begin
                  hold_count <= hold_count + 3'h1;
               end
            end
            pmi_pkg::PMI_HELD: begin
               state <= pmi_pkg::PMI_HELD;
            end
         endcase
      end
   end

   // One-cycle event on entry to the held state.
   assign set_event = cond && state == pmi_pkg::PMI_COUNT &&
                      hold_count == 3'(`PMI_HOLD_CLOCKS);

   // ---------------------------------------------------------------
   // Control register and flags
   // ---------------------------------------------------------------

   // Control bits; hardware set of the flag wins over a software clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_control_reg <= '0;
      end else begin
         if (wr && paddr == `PMI_OFF_CONTROL) begin
            match_control_reg.polarity <= pwdata[`PMI_CTL_POLARITY];
            match_control_reg.enable   <= pwdata[`PMI_CTL_ENABLE];
            if (!pwdata[`PMI_CTL_FLAG])
               match_control_reg.flag <= 1'b0;
         end
         if (set_event)
            match_control_reg.flag <= 1'b1;
      end
   end

   // Sticky status, cleared by writing one; set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 1'b0;
      end else if (set_event) begin
         irq_status <= 1'b1;
      end else if (wr && paddr == `PMI_OFF_IRQ_STAT && pwdata[0]) begin
         irq_status <= 1'b0;
      end
   end

   // Interrupt and wake are registered levels from status and mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pattern_match_interrupt <= 1'b0;
         wake_request            <= 1'b0;
      end else begin
         pattern_match_interrupt <= irq_status & irq_mask;
         wake_request            <= irq_status & irq_mask;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_no_early_set;
      @(posedge pclk) disable iff (!presetn)
      $rose(match_control_reg.flag) |-> $past(cond, 1) && $past(cond, 7);
   endproperty
   a_no_early_set: assert property (p_no_early_set)
      else $error("Flag set before condition held long enough.");

   property p_held_sets;
      @(posedge pclk) disable iff (!presetn)
      cond [*8] |-> match_control_reg.flag || $past(wr);
   endproperty
   a_held_sets: assert property (p_held_sets)
      else $error("Flag not set after condition held.");

   property p_mask_blocks;
      @(posedge pclk) disable iff (!presetn)
      (pin_select_mask == '0 && match_control_reg.polarity) |-> !cond;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("Unselected pins produced a match.");

   property p_equal_compare;
      @(posedge pclk) disable iff (!presetn)
      (match_control_reg.enable && !match_control_reg.polarity &&
       port_in == match_pattern_value) |-> cond;
   endproperty
   a_equal_compare: assert property (p_equal_compare)
      else $error("Equal port value did not match.");

   property p_polarity;
      @(posedge pclk) disable iff (!presetn)
      (match_control_reg.enable && match_control_reg.polarity &&
       port_in == match_pattern_value) |-> !cond;
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("Not-equal mode matched an equal value.");

   property p_irq_follows;
      @(posedge pclk) disable iff (!presetn)
      (irq_status && irq_mask) |=> pattern_match_interrupt;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("Interrupt not raised for enabled event.");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      (irq_status && irq_mask) |=> wake_request;
   endproperty
   a_wake: assert property (p_wake)
      else $error("Wake request missing with interrupt.");

   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
      match_control_reg.flag && !$past(wr) |-> ##0 1'b1 ##1
      (match_control_reg.flag || $past(wr && paddr == `PMI_OFF_CONTROL));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Flag cleared without a software write.");

   property p_irq_clear;
      @(posedge pclk) disable iff (!presetn)
      !(irq_status && irq_mask) |=> !pattern_match_interrupt;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("Interrupt stayed high without an enabled event.");

   property p_wake_clear;
      @(posedge pclk) disable iff (!presetn)
      !(irq_status && irq_mask) |=> !wake_request;
   endproperty
   a_wake_clear: assert property (p_wake_clear)
      else $error("Wake request stayed high without an enabled event.");

   property p_status_with_flag;
      @(posedge pclk) disable iff (!presetn)
      $rose(match_control_reg.flag) |-> irq_status;
   endproperty
   a_status_with_flag: assert property (p_status_with_flag)
      else $error("Flag set without an interrupt status.");

   property p_single_event;
      @(posedge pclk) disable iff (!presetn)
      set_event |=> !set_event;
   endproperty
   a_single_event: assert property (p_single_event)
      else $error("Match event lasted more than one cycle.");

   property p_disabled_no_set;
      @(posedge pclk) disable iff (!presetn)
      !match_control_reg.enable |=> !$rose(match_control_reg.flag);
   endproperty
   a_disabled_no_set: assert property (p_disabled_no_set)
      else $error("Flag set while the function was off.");

   property p_short_no_set;
      @(posedge pclk) disable iff (!presetn)
      !cond ##1 cond [*6] ##1 !cond |=> !$rose(match_control_reg.flag);
   endproperty
   a_short_no_set: assert property (p_short_no_set)
      else $error("Flag set by a condition held only six cycles.");

   property p_flag_clear_src;
      @(posedge pclk) disable iff (!presetn)
      $fell(match_control_reg.flag) |->
      $past(wr && paddr == `PMI_OFF_CONTROL && !pwdata[`PMI_CTL_FLAG]);
   endproperty
   a_flag_clear_src: assert property (p_flag_clear_src)
      else $error("Flag cleared without a zero written to it.");

   property p_status_clear_src;
      @(posedge pclk) disable iff (!presetn)
      $fell(irq_status) |->
      $past(wr && paddr == `PMI_OFF_IRQ_STAT && pwdata[0]);
   endproperty
   a_status_clear_src: assert property (p_status_clear_src)
      else $error("Status cleared without a one written to it.");

   property p_count_bound;
      @(posedge pclk) disable iff (!presetn)
      hold_count <= 3'(`PMI_HOLD_CLOCKS);
   endproperty
   a_count_bound: assert property (p_count_bound)
      else $error("Hold counter ran past its limit.");

   property p_unselected_ignored;
      @(posedge pclk) disable iff (!presetn)
      (match_control_reg.enable && match_control_reg.polarity &&
       (port_in | ~pin_select_mask) ==
       (match_pattern_value | ~pin_select_mask)) |-> !cond;
   endproperty
   a_unselected_ignored: assert property (p_unselected_ignored)
      else $error("A pin outside the mask produced a match.");

   c_match: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(match_control_reg.flag));
   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(pattern_match_interrupt));
   c_short: cover property (@(posedge pclk) disable iff (!presetn)
      cond [*3] ##1 !cond);
   c_equal: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(match_control_reg.flag) && !match_control_reg.polarity);

endmodule
`default_nettype wire

// ===== core/pmi_params.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH

// Register byte offsets.
`define PMI_OFF_MASK     12'h000
`define PMI_OFF_PATTERN  12'h004
`define PMI_OFF_CONTROL  12'h008
`define PMI_OFF_IRQ_STAT 12'h00C
`define PMI_OFF_IRQ_MASK 12'h010
`define PMI_OFF_PORT     12'h014

// Control register fields.
`define PMI_CTL_FLAG     0
`define PMI_CTL_POLARITY 1
`define PMI_CTL_ENABLE   2

// Reset values.
`define PMI_RST_MASK     8'h00
`define PMI_RST_PATTERN  8'h00

// Match must persist more than this many core clocks.
`define PMI_HOLD_CLOCKS  6

`endif

// ===== core/pmi_pkg.sv
// Types shared by the pattern-match interrupt block.
`default_nettype none
package pmi_pkg;

   // Decoded control register fields.
   typedef struct packed {
      logic enable;
      logic polarity;
      logic flag;
   } pmi_ctl_s;

   // Qualifier state of the match condition.
   typedef enum logic [1:0] {
      PMI_IDLE,
      PMI_COUNT,
      PMI_HELD
   } pmi_state_e;

endpackage
`default_nettype wire

// ===== sim/pmi_keypad.sv
// Keypad and signal source model that drives the port pins.
`timescale 1ns/10ps
`default_nettype none

module pmi_keypad (
   // Drive requests from the bench.
   input  wire logic [7:0] drive_en,
   input  wire logic [7:0] drive_val,
   // Port pins.
   output logic      [7:0] port_in
);
   // ------------------------------------------------------------
   // Pin levels
   // ------------------------------------------------------------
   // A released pin floats up to its pull-up, so an idle pad reads ones.
   assign port_in = (drive_val & drive_en) | ~drive_en;
endmodule

`default_nettype wire

// ===== sim/test_port_pattern_match_interrupt.sv
// Self-checking bench for the port pattern-match interrupt unit.
`timescale 1ns/10ps
`default_nettype none
`include "pmi_params.svh"

module test_port_pattern_match_interrupt;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  port_in;
   logic        irq;
   logic        wake;
   logic [7:0]  key_en;
   logic [7:0]  key_val;
   logic [31:0] rd;
   logic        rd_err;
   int          err_count;
   int          checks_done;

   // ------------------------------------------------------------
   // Clock, design and pin model
   // ------------------------------------------------------------
   // The clock toggles every half period of 10 ns.
   always #10 pclk = ~pclk;

   pmi_match #(.WIDTH(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_in(port_in),
      .pattern_match_interrupt(irq), .wake_request(wake)
   );

   pmi_keypad u_keys (
      .drive_en(key_en), .drive_val(key_val), .port_in(port_in)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Compares a value and reports a mismatch at once.
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp_v);
      checks_done++;
      if (seen !== exp_v) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp_v, seen);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic tally_and_finish;
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One APB transfer; an idle cycle follows so strobes never rise twice.
   task automatic apb(input logic wr, input logic [11:0] addr,
                      input logic [31:0] data);
      int n;
      n = 0;
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd     = prdata;
      rd_err = pslverr;
      if (n >= 20) begin
         err_count++;
         tally_and_finish();
      end
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // Reads a register and compares it.
   task automatic rreg(input string what, input logic [11:0] addr,
                       input logic [31:0] exp_v);
      apb(1'h0, addr, 32'h00000000);
      chk(what, rd, exp_v);
   endtask

   // Drives pins for a number of clocks, then releases them.
   task automatic hold(input logic [7:0] en, input logic [7:0] val,
                       input int n);
      key_en  <= en;
      key_val <= val;
      repeat (n) @(posedge pclk);
      key_en  <= 8'h00;
      key_val <= 8'h00;
      repeat (3) @(posedge pclk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset values and an unmapped address.
   task automatic reset_values;
      rreg("mask", `PMI_OFF_MASK, 32'h00000000);
      rreg("pattern", `PMI_OFF_PATTERN, 32'h00000000);
      rreg("control", `PMI_OFF_CONTROL, 32'h00000000);
      rreg("irq stat", `PMI_OFF_IRQ_STAT, 32'h00000000);
      rreg("irq mask", `PMI_OFF_IRQ_MASK, 32'h00000000);
      rreg("port idle", `PMI_OFF_PORT, 32'h000000FF);
      apb(1'h0, 12'h0FC, 32'h00000000);
      chk("unmapped err", {31'h0, rd_err}, 32'h00000001);
      chk("unmapped data", rd, 32'h00000000);
   endtask

   // Keypad use: no pins, masked pin, short and boundary press, clearing.
   task automatic keypad_press;
      apb(1'h1, `PMI_OFF_PATTERN, 32'h000000FF);
      apb(1'h1, `PMI_OFF_CONTROL, 32'h00000006);
      hold(8'h04, 8'h00, 12);
      rreg("ctl no pins", `PMI_OFF_CONTROL, 32'h00000006);
      apb(1'h1, `PMI_OFF_MASK, 32'h0000000F);
      apb(1'h1, `PMI_OFF_IRQ_MASK, 32'h00000001);
      rreg("irq mask set", `PMI_OFF_IRQ_MASK, 32'h00000001);
      hold(8'h80, 8'h00, 12);
      rreg("ctl masked pin", `PMI_OFF_CONTROL, 32'h00000006);
      hold(8'h04, 8'h00, 6);
      rreg("ctl short", `PMI_OFF_CONTROL, 32'h00000006);
      chk("irq short", {31'h0, irq}, 32'h00000000);
      hold(8'h04, 8'h00, 7);
      rreg("ctl flag", `PMI_OFF_CONTROL, 32'h00000007);
      rreg("stat set", `PMI_OFF_IRQ_STAT, 32'h00000001);
      chk("irq", {31'h0, irq}, 32'h00000001);
      chk("wake", {31'h0, wake}, 32'h00000001);
      apb(1'h1, `PMI_OFF_CONTROL, 32'h00000007);
      rreg("ctl kept", `PMI_OFF_CONTROL, 32'h00000007);
      apb(1'h1, `PMI_OFF_IRQ_STAT, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk("irq cleared", {31'h0, irq}, 32'h00000000);
      chk("wake cleared", {31'h0, wake}, 32'h00000000);
      apb(1'h1, `PMI_OFF_CONTROL, 32'h00000006);
      rreg("ctl zeroed", `PMI_OFF_CONTROL, 32'h00000006);
   endtask

   // Equal mode, interrupt masking and a disabled function.
   task automatic equal_mode;
      apb(1'h1, `PMI_OFF_MASK, 32'h000000FF);
      apb(1'h1, `PMI_OFF_PATTERN, 32'h000000A5);
      apb(1'h1, `PMI_OFF_CONTROL, 32'h00000004);
      hold(8'hFF, 8'hA4, 12);
      rreg("ctl near", `PMI_OFF_CONTROL, 32'h00000004);
      hold(8'hFF, 8'hA5, 12);
      rreg("ctl equal", `PMI_OFF_CONTROL, 32'h00000005);
      apb(1'h1, `PMI_OFF_IRQ_MASK, 32'h00000000);
      repeat (2) @(posedge pclk);
      chk("irq masked", {31'h0, irq}, 32'h00000000);
      apb(1'h1, `PMI_OFF_IRQ_STAT, 32'h00000001);
      apb(1'h1, `PMI_OFF_CONTROL, 32'h00000000);
      hold(8'hFF, 8'hA5, 12);
      rreg("ctl off", `PMI_OFF_CONTROL, 32'h00000000);
      rreg("stat off", `PMI_OFF_IRQ_STAT, 32'h00000000);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   // Resets for four clocks, then runs every scenario.
   initial begin
      err_count   = 0;
      checks_done = 0;
      pclk        = 1'h0;
      presetn     = 1'h0;
      psel        = 1'h0;
      penable     = 1'h0;
      pwrite      = 1'h0;
      paddr       = 12'h000;
      pwdata      = 32'h00000000;
      key_en      = 8'h00;
      key_val     = 8'h00;
      repeat (4) @(posedge pclk);
      chk("irq in reset", {31'h0, irq}, 32'h00000000);
      presetn <= 1'h1;
      @(posedge pclk);
      reset_values();
      keypad_press();
      equal_mode();
      tally_and_finish();
   end
endmodule

`default_nettype wire
